/* File: rtl/fpu_port_pkg.sv */
// constants for the floating-point processor bus interface
package fpu_port_pkg;
    localparam int          DATA_W        = 32;
    localparam int          ADDR_W        = 16;
    localparam int          BOOT_WORDS    = 65;
    localparam int          BLOCK_MAX     = 512;
    localparam int          BLK_CNT_W     = 10;
    localparam int          REG_IDX_W     = 5;
    localparam int          REG_COUNT     = 32;
    localparam logic [31:0] CONFIG_INIT   = 32'hffe00420;
    localparam logic [15:0] CODE_ORIGIN   = 16'h0000;
    localparam logic [9:0]  BLK_ONE       = 10'h001;
    localparam logic [4:0]  RESULT_REG    = 5'h00;
    localparam int          FIFO_DEPTH    = 4;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_BOOT   = 3'b001,
        ST_RUN    = 3'b010,
        ST_TO_EXP = 3'b011,
        ST_TO_LOC = 3'b100
    } seq_state_e;
endpackage : fpu_port_pkg

/* File: rtl/word_fifo.sv */
// small flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             clk_en,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
    logic [PW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    assign in_ready  = (cnt_reg != (PW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_next  = push ? PW'((wr_reg + 1'b1) % DEPTH) : wr_reg;
        rd_next  = pop ? PW'((rd_reg + 1'b1) % DEPTH) : rd_reg;
        cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else if (clk_en) begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
            if (push) begin
                mem_reg[wr_reg] <= in_data;
            end
        end
    end
endmodule : word_fifo
`default_nettype wire

/* File: rtl/fpu_bus_interface_bootstrap.sv */
// bus interface, data flow control and bootstrap loader
// Overview of operation
// - stall input low freezes sequencer, fifo and datapath registers without loss; input synchronisers keep sampling.
// - while stalled only write strobe and local bus enable pins can change, following the host mode select synchroniser.
// - reset clears sequencer, pipeline, state, status, exception disables only.
// - coprocessor mode: type select high means instruction, low means memory operand.
// - write strobe is host input in coprocessor mode, device output standalone.
// - two bidirectional 32-bit data buses plus 16-bit expansion address bus.
// - data/code space output selects data or program memory, 64K each.
// - coprocessor mode takes instructions and data on local bus, optional program fetch.
// - standalone supports local-only data or data on either port.
// - one 32-bit operand per cycle; double takes two consecutive cycles.
// - one move instruction transfers a block of operands.
// - block transfers between buses, either direction: up to 512 words, or 512 doubles (1024 words) toward local.
// - standalone: one core operand may come straight from local bus.
// - standalone: result written to register and local bus together.
// - boot loader reads 65 local words, copies the last 64 to program memory, then runs at zero.
// - first boot word goes into the configuration register.
// - memory write enable low while expansion bus carries write data.
// - configuration register initial value is ffe00420.
`timescale 1ns/1ns
`default_nettype none
module fpu_bus_interface_bootstrap
    import fpu_port_pkg::*;
#(
    parameter int BOOT_LEN = fpu_port_pkg::BOOT_WORDS
) (
    input  wire logic                           clock,
    input  wire logic                           rst,
    input  wire logic                           clk_en,
    input  wire logic                           ready_pin,
    input  wire logic                           host_mode_select,
    input  wire logic                           operand_type_select,
    input  wire logic                           row_strobe,
    input  wire logic                           write_n_in,
    output logic                                write_n_out,
    output logic                                write_n_oe,
    input  wire logic [fpu_port_pkg::DATA_W-1:0] local_addr_data_bus_in,
    output logic      [fpu_port_pkg::DATA_W-1:0] local_addr_data_bus_out,
    output logic                                local_addr_data_bus_oe,
    input  wire logic [fpu_port_pkg::DATA_W-1:0] expansion_data_bus_in,
    output logic      [fpu_port_pkg::DATA_W-1:0] expansion_data_bus_out,
    output logic                                expansion_data_bus_oe,
    output logic      [fpu_port_pkg::ADDR_W-1:0] expansion_addr_bus,
    output logic                                data_code_space_sel,
    output logic                                expansion_write_n,
    input  wire logic                           move_start,
    input  wire logic                           move_to_exp,
    input  wire logic [fpu_port_pkg::BLK_CNT_W-1:0] move_len,
    input  wire logic [fpu_port_pkg::ADDR_W-1:0] move_addr,
    input  wire logic                           move_data_space,
    input  wire logic                           double_op,
    input  wire logic [fpu_port_pkg::REG_IDX_W-1:0] move_reg,
    input  wire logic [fpu_port_pkg::DATA_W-1:0] core_result,
    input  wire logic                           core_result_valid,
    output logic                                core_operand_local_sel,
    output logic      [fpu_port_pkg::DATA_W-1:0] core_operand,
    output logic      [fpu_port_pkg::DATA_W-1:0] config_value,
    output logic                                instr_valid,
    output logic      [fpu_port_pkg::DATA_W-1:0] instr_word,
    output logic                                busy,
    output logic      [fpu_port_pkg::ADDR_W-1:0] program_counter
);
    import fpu_port_pkg::*;

    // ----------------------------------------------------------------
    // input synchronisers and stall
    // ----------------------------------------------------------------
    logic [1:0] rdy_sync, mode_sync, ots_sync, row_sync, wen_sync;
    logic       run_en, standalone;

    always_ff @(posedge clock) begin
        if (rst) begin
            rdy_sync  <= 2'h0;
            mode_sync <= 2'h0;
            ots_sync  <= 2'h0;
            row_sync  <= 2'h0;
            wen_sync  <= 2'h3;
        end else if (clk_en) begin
            rdy_sync  <= {rdy_sync[0], ready_pin};
            mode_sync <= {mode_sync[0], host_mode_select};
            ots_sync  <= {ots_sync[0], operand_type_select};
            row_sync  <= {row_sync[0], row_strobe};
            wen_sync  <= {wen_sync[0], write_n_in};
        end
    end

    assign run_en     = clk_en && rdy_sync[1];
    assign standalone = mode_sync[1];

    // ----------------------------------------------------------------
    // local bus input fifo
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] loc_in_s, loc_in_q;
    logic [DATA_W-1:0] fifo_data;
    logic              fifo_valid, fifo_ready, fifo_in_ready, loc_strobe, ots_q;

    always_ff @(posedge clock) begin
        if (clk_en) begin
            loc_in_s <= local_addr_data_bus_in;
            loc_in_q <= loc_in_s;
        end
    end

    // coprocessor word taken when host strobe and row strobe line up
    assign loc_strobe = standalone ? 1'b1 : (!wen_sync[1] && row_sync[1]);

    word_fifo #(.WIDTH(DATA_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock     (clock),
        .rst       (rst),
        .clk_en    (run_en),
        .in_data   ({ots_sync[1], loc_in_q}),
        .in_valid  (loc_strobe && !local_addr_data_bus_oe),
        .in_ready  (fifo_in_ready),
        .out_data  ({ots_q, fifo_data}),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    seq_state_e        st_reg, st_next;
    logic [ADDR_W-1:0] addr_reg, addr_next, pc_reg, pc_next;
    logic [BLK_CNT_W-1:0] cnt_reg, cnt_next;
    logic [REG_IDX_W-1:0] ridx_reg, ridx_next;
    logic              half_reg, half_next, dsp_reg, dsp_next;
    logic              wr_reg, wr_next, ioe_reg, ioe_next, moe_reg, moe_next;
    logic [DATA_W-1:0] mout_reg, mout_next, lout_reg, lout_next;
    logic [DATA_W-1:0] cfg_reg, cfg_next, instr_reg, instr_next;
    logic              iv_reg, iv_next, lsel_reg, lsel_next;
    logic [DATA_W-1:0] opnd_reg, opnd_next;
    logic [DATA_W-1:0] dreg [REG_COUNT];
    logic              dreg_we;
    logic [DATA_W-1:0] dreg_wd;

    function automatic logic last_word(input logic [BLK_CNT_W-1:0] c);
        return c <= BLK_ONE;
    endfunction : last_word

    always_comb begin
        st_next    = st_reg;
        addr_next  = addr_reg;
        pc_next    = pc_reg;
        cnt_next   = cnt_reg;
        ridx_next  = ridx_reg;
        half_next  = half_reg;
        dsp_next   = dsp_reg;
        wr_next    = 1'b0;
        moe_next   = 1'b0;
        ioe_next   = 1'b0;
        mout_next  = mout_reg;
        lout_next  = lout_reg;
        cfg_next   = cfg_reg;
        instr_next = instr_reg;
        iv_next    = 1'b0;
        lsel_next  = 1'b0;
        opnd_next  = opnd_reg;
        fifo_ready = 1'b0;
        dreg_we    = 1'b0;
        dreg_wd    = fifo_data;
        case (st_reg)
            ST_IDLE: begin
                half_next = 1'b0;
                if (standalone) begin
                    st_next   = ST_BOOT;
                    cnt_next  = BLK_CNT_W'(BOOT_LEN);
                    addr_next = CODE_ORIGIN;
                end else begin
                    st_next = ST_RUN;
                end
            end
            ST_BOOT: begin
                fifo_ready = 1'b1;
                addr_next  = addr_reg + ADDR_W'(wr_reg);
                if (fifo_valid) begin
                    if (half_reg) begin
                        mout_next = fifo_data;
                        moe_next  = 1'b1;
                        wr_next   = 1'b1;
                        dsp_next  = 1'b0;
                    end else begin
                        cfg_next  = fifo_data;
                    end
                    half_next = 1'b1;
                    cnt_next  = cnt_reg - 1'b1;
                    if (last_word(cnt_reg)) begin
                        st_next = ST_RUN;
                        pc_next = CODE_ORIGIN;
                    end
                end
            end
            ST_RUN: begin
                if (move_start) begin
                    cnt_next  = (move_len > BLK_CNT_W'(BLOCK_MAX)) ? BLK_CNT_W'(BLOCK_MAX)
                                                                  : move_len;
                    addr_next = move_addr;
                    ridx_next = move_reg;
                    dsp_next  = move_data_space;
                    half_next = 1'b0;
                    st_next   = move_to_exp ? ST_TO_EXP : ST_TO_LOC;
                end else if (core_result_valid && standalone) begin
                    lout_next = core_result;
                    ioe_next  = 1'b1;
                    dreg_we   = 1'b1;
                    dreg_wd   = core_result;
                    ridx_next = RESULT_REG;
                end else begin
                    fifo_ready = 1'b1;
                    if (fifo_valid) begin
                        if (standalone) begin
                            opnd_next = fifo_data;
                            lsel_next = 1'b1;
                        end else if (ots_q) begin
                            instr_next = fifo_data;
                            iv_next    = 1'b1;
                        end else begin
                            dreg_we   = 1'b1;
                            ridx_next = ridx_reg + 1'b1;
                        end
                    end
                end
            end
            ST_TO_EXP: begin
                fifo_ready = 1'b1;
                addr_next  = addr_reg + ADDR_W'(wr_reg);
                if (fifo_valid) begin
                    mout_next = fifo_data;
                    moe_next  = 1'b1;
                    wr_next   = 1'b1;
                    cnt_next  = cnt_reg - 1'b1;
                    if (last_word(cnt_reg)) begin
                        st_next = ST_RUN;
                    end
                end
            end
            ST_TO_LOC: begin
                // one word per cycle; doubles take two cycles
                lout_next = expansion_data_bus_in;
                ioe_next  = 1'b1;
                dreg_we   = 1'b1;
                dreg_wd   = expansion_data_bus_in;
                ridx_next = ridx_reg + 1'b1;
                addr_next = addr_reg + 1'b1;
                half_next = double_op ? !half_reg : 1'b0;
                if (!(double_op && !half_reg)) begin
                    cnt_next = cnt_reg - 1'b1;
                    if (last_word(cnt_reg)) begin
                        st_next = ST_RUN;
                    end
                end
            end
            default: st_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st_reg   <= ST_IDLE;
            pc_reg   <= '0;
            half_reg <= 1'b0;
            wr_reg   <= 1'b0;
            ioe_reg  <= 1'b0;
            moe_reg  <= 1'b0;
            iv_reg   <= 1'b0;
            lsel_reg <= 1'b0;
            cfg_reg  <= CONFIG_INIT;
        end else if (run_en) begin
            st_reg   <= st_next;
            pc_reg   <= pc_next;
            half_reg <= half_next;
            wr_reg   <= wr_next;
            ioe_reg  <= ioe_next;
            moe_reg  <= moe_next;
            iv_reg   <= iv_next;
            lsel_reg <= lsel_next;
            cfg_reg  <= cfg_next;
        end
    end

    // datapath registers are left untouched by reset
    always_ff @(posedge clock) begin
        if (run_en) begin
            addr_reg  <= addr_next;
            cnt_reg   <= cnt_next;
            ridx_reg  <= ridx_next;
            dsp_reg   <= dsp_next;
            mout_reg  <= mout_next;
            lout_reg  <= lout_next;
            instr_reg <= instr_next;
            opnd_reg  <= opnd_next;
            if (dreg_we) begin
                dreg[ridx_reg] <= dreg_wd;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign expansion_addr_bus      = addr_reg;
    assign data_code_space_sel     = dsp_reg;
    assign expansion_write_n       = !wr_reg;
    assign expansion_data_bus_out  = mout_reg;
    assign expansion_data_bus_oe   = moe_reg;
    assign local_addr_data_bus_out = lout_reg;
    assign local_addr_data_bus_oe  = ioe_reg && standalone;
    assign write_n_out             = !(ioe_reg && standalone);
    assign write_n_oe              = standalone;
    assign config_value            = cfg_reg;
    assign instr_word              = instr_reg;
    assign instr_valid             = iv_reg;
    assign core_operand            = opnd_reg;
    assign core_operand_local_sel  = lsel_reg;
    assign busy                    = (st_reg != ST_RUN) || !fifo_in_ready;
    assign program_counter         = pc_reg;
endmodule : fpu_bus_interface_bootstrap
`default_nettype wire

/* File: test/fpu_port_props.sv */
// assertions on the bus interface and boot loader ports
`timescale 1ns/1ns
`default_nettype none
module fpu_port_props
    import fpu_port_pkg::*;
(
    input wire logic                             clock,
    input wire logic                             rst,
    input wire logic                             clk_en,
    input wire logic                             ready_pin,
    input wire logic                             host_mode_select,
    input wire logic                             move_start,
    input wire logic                             busy,
    input wire logic                             write_n_out,
    input wire logic                             local_addr_data_bus_oe,
    input wire logic [fpu_port_pkg::DATA_W-1:0]  local_addr_data_bus_out,
    input wire logic                             expansion_data_bus_oe,
    input wire logic [fpu_port_pkg::DATA_W-1:0]  expansion_data_bus_out,
    input wire logic [fpu_port_pkg::ADDR_W-1:0]  expansion_addr_bus,
    input wire logic                             data_code_space_sel,
    input wire logic                             expansion_write_n,
    input wire logic [fpu_port_pkg::DATA_W-1:0]  config_value,
    input wire logic [fpu_port_pkg::ADDR_W-1:0]  program_counter
);
    import fpu_port_pkg::*;
    // ----------------------------------------
    // helper: recent cycles free of stall
    // ----------------------------------------
    logic [3:0]   run_hist_reg;
    logic [3:0]   run_hist_next;
    wire  [133:0] outs = {write_n_out, local_addr_data_bus_oe, local_addr_data_bus_out,
        expansion_data_bus_oe, expansion_data_bus_out, expansion_addr_bus,
        data_code_space_sel, expansion_write_n, config_value, busy, program_counter};
    always_comb run_hist_next = {run_hist_reg[2:0], ready_pin & clk_en};
    always_ff @(posedge clock) run_hist_reg <= run_hist_next;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_reset_state;
        $fell(rst) |-> expansion_write_n && !expansion_data_bus_oe && !local_addr_data_bus_oe
            && config_value == CONFIG_INIT;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad state after reset");
    property p_stall_hold;
        !ready_pin [*3] |=> outs === $past(outs);
    endproperty
    a_stall_hold: assert property (p_stall_hold) else $error("output moved in stall");
    property p_freeze;
        !clk_en |=> outs === $past(outs);
    endproperty
    a_freeze: assert property (p_freeze) else $error("output moved while frozen");
    property p_write_drives;
        !expansion_write_n |-> expansion_data_bus_oe;
    endproperty
    a_write_drives: assert property (p_write_drives) else $error("write without data");
    property p_addr_seq;
        !expansion_write_n && $past(!expansion_write_n) && (&run_hist_reg) && !$past(rst)
            |-> expansion_addr_bus == $past(expansion_addr_bus) + 16'h0001;
    endproperty
    a_addr_seq: assert property (p_addr_seq) else $error("write address not sequential");
    property p_local_mode;
        local_addr_data_bus_oe |-> host_mode_select;
    endproperty
    a_local_mode: assert property (p_local_mode) else $error("local bus driven in coproc");
    property p_strobe_out;
        !write_n_out |-> local_addr_data_bus_oe;
    endproperty
    a_strobe_out: assert property (p_strobe_out) else $error("strobe without local data");
    property p_move_busy;
        move_start && !busy && clk_en && ready_pin |-> ##[1:4] busy;
    endproperty
    a_move_busy: assert property (p_move_busy) else $error("move did not start");
    property p_config_boot;
        $changed(config_value) && !$past(rst) |-> host_mode_select;
    endproperty
    a_config_boot: assert property (p_config_boot) else $error("config changed in coproc");
    c_mem_write: cover property (!expansion_write_n);
    c_move: cover property (move_start && !busy);
    c_stall: cover property (!ready_pin [*3]);
    c_local_out: cover property (local_addr_data_bus_oe);
endmodule : fpu_port_props
bind fpu_bus_interface_bootstrap fpu_port_props u_fpu_port_props (.clock, .rst, .clk_en,
    .ready_pin, .host_mode_select, .move_start, .busy, .write_n_out, .local_addr_data_bus_oe,
    .local_addr_data_bus_out, .expansion_data_bus_oe, .expansion_data_bus_out,
    .expansion_addr_bus, .data_code_space_sel, .expansion_write_n, .config_value,
    .program_counter);
`default_nettype wire

/* File: test/exp_memory_model.sv */
// external program and data memory on the expansion port
`timescale 1ns/1ns
`default_nettype none
module exp_memory_model
    import fpu_port_pkg::*;
(
    input  wire logic                            clock,
    input  wire logic [fpu_port_pkg::ADDR_W-1:0] expansion_addr_bus,
    input  wire logic                            data_code_space_sel,
    input  wire logic                            expansion_write_n,
    input  wire logic [fpu_port_pkg::DATA_W-1:0] expansion_data_bus_out,
    input  wire logic                            expansion_data_bus_oe,
    output logic      [fpu_port_pkg::DATA_W-1:0] expansion_data_bus_in
);
    import fpu_port_pkg::*;
    logic [DATA_W-1:0] code_mem [0:65535];
    logic [DATA_W-1:0] data_mem [0:65535];
    int                n_writes;
    logic [ADDR_W:0]   last_wr;
    initial begin
        n_writes = 0;
        for (int i = 0; i < 65536; i++) begin
            code_mem[i] = ~32'(i);
            data_mem[i] = ~32'(i);
        end
    end
    // store every write; one held through a stall counts once
    always @(posedge clock) begin
        last_wr <= {expansion_write_n, expansion_addr_bus};
        if (expansion_write_n === 1'b0) begin
            n_writes <= n_writes + int'(last_wr !== {1'b0, expansion_addr_bus});
            if (data_code_space_sel) begin
                data_mem[expansion_addr_bus] <= expansion_data_bus_out;
            end else begin
                code_mem[expansion_addr_bus] <= expansion_data_bus_out;
            end
        end
    end
    // memory answers whenever the device leaves the bus
    assign expansion_data_bus_in = expansion_data_bus_oe ? expansion_data_bus_out :
        (data_code_space_sel ? data_mem[expansion_addr_bus] : code_mem[expansion_addr_bus]);
endmodule : exp_memory_model
`default_nettype wire

/* File: test/tb_fpu_bus_interface_bootstrap.sv */
// self-checking bench for the bus interface and boot loader
`timescale 1ns/1ns
`default_nettype none
module tb_fpu_bus_interface_bootstrap;
    import fpu_port_pkg::*;
    logic        clock, rst, clk_en, ready_pin, host_mode_select, operand_type_select;
    logic        row_strobe, write_n_in, move_start, move_to_exp, move_data_space, double_op;
    logic        core_result_valid, write_n_out, write_n_oe, local_addr_data_bus_oe;
    logic        expansion_data_bus_oe, data_code_space_sel, expansion_write_n;
    logic        core_operand_local_sel, instr_valid, busy;
    logic [9:0]  move_len;
    logic [4:0]  move_reg;
    logic [15:0] move_addr, expansion_addr_bus, program_counter;
    logic [31:0] core_result, loc_drive, local_addr_data_bus_out, expansion_data_bus_in;
    logic [31:0] expansion_data_bus_out, core_operand, config_value, instr_word, snap;
    wire  [31:0] local_addr_data_bus_in = local_addr_data_bus_oe ? local_addr_data_bus_out
                                                                 : loc_drive;
    int          n_errors, n_compared, cycles, base;
    fpu_bus_interface_bootstrap #(.BOOT_LEN(3)) u_fpu_bus_interface_bootstrap (.*);
    exp_memory_model u_exp_memory_model (.*);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic do_reset(input logic mode);
        @(negedge clock);
        rst = 1'b1;
        host_mode_select = mode;
        repeat (20) @(negedge clock);
        rst = 1'b0;
    endtask : do_reset
    task automatic host_write(input logic [31:0] w, input logic t);
        loc_drive = w;
        operand_type_select = t;
        write_n_in = 1'b0;
        @(negedge clock);
    endtask : host_write
    task automatic finish_test;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        do_reset(1'b0);
        check(config_value, CONFIG_INIT);
        check(expansion_write_n, 1'b1);
        check({local_addr_data_bus_oe, expansion_data_bus_oe}, 2'b00);
        check(write_n_oe, 1'b0);
    endtask : t_reset
    task automatic t_instr;
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clock);
        host_write(32'h0a5a_0001, 1'b1);
        write_n_in = 1'b1;
        for (int i = 0; i < 40 && instr_valid !== 1'b1; i++) @(negedge clock);
        check(instr_valid, 1'b1);
        check(instr_word, 32'h0a5a_0001);
    endtask : t_instr
    task automatic t_move;
        clk_en = 1'b0;
        repeat (3) @(negedge clock);
        clk_en = 1'b1;
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge clock);
        base = u_exp_memory_model.n_writes;
        move_len = 10'h003;
        move_addr = 16'h0100;
        move_start = 1'b1;
        @(negedge clock);
        move_start = 1'b0;
        for (int i = 0; i < 3; i++) host_write(32'hd000_0000 + 32'(i), 1'b0);
        write_n_in = 1'b1;
        ready_pin = 1'b0;
        repeat (4) @(negedge clock);
        snap = {expansion_addr_bus, 15'h0000, expansion_write_n};
        base = u_exp_memory_model.n_writes;
        repeat (8) @(negedge clock);
        check({expansion_addr_bus, 15'h0000, expansion_write_n}, snap);
        check(32'(u_exp_memory_model.n_writes), 32'(base));
        ready_pin = 1'b1;
        for (int i = 0; i < 60 && busy !== 1'b0; i++) @(negedge clock);
        @(negedge clock);
        for (int i = 0; i < 3; i++) begin
            check(u_exp_memory_model.data_mem[16'h0100 + 16'(i)], 32'hd000_0000 + 32'(i));
        end
    endtask : t_move
    task automatic t_boot;
        loc_drive = 32'h1234_5678;
        do_reset(1'b1);
        base = u_exp_memory_model.n_writes;
        @(negedge clock);
        loc_drive = 32'h0bad_0001;
        @(negedge clock);
        loc_drive = 32'h0bad_0002;
        @(negedge clock);
        loc_drive = 32'hcafe_0003;
        for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clock);
        @(negedge clock);
        check(write_n_oe, 1'b1);
        check(config_value, 32'h1234_5678);
        check(u_exp_memory_model.code_mem[0], 32'h0bad_0001);
        check(u_exp_memory_model.code_mem[1], 32'h0bad_0002);
        check(32'(u_exp_memory_model.n_writes - base), 32'h0000_0002);
        check(32'(program_counter), 32'h0000_0000);
        for (int i = 0; i < 20 && core_operand_local_sel !== 1'b1; i++) @(negedge clock);
        check(core_operand, 32'hcafe_0003);
        check(core_operand_local_sel, 1'b1);
        core_result = 32'h3f80_0000;
        core_result_valid = 1'b1;
        @(negedge clock);
        core_result_valid = 1'b0;
        for (int i = 0; i < 20 && local_addr_data_bus_oe !== 1'b1; i++) @(negedge clock);
        check(local_addr_data_bus_out, 32'h3f80_0000);
        check(write_n_out, 1'b0);
    endtask : t_boot
    initial begin
        {rst, clk_en, ready_pin, row_strobe, write_n_in} = 5'b11111;
        {host_mode_select, operand_type_select, move_start, double_op} = 4'h0;
        {move_to_exp, move_data_space, core_result_valid} = 3'b110;
        {n_errors, n_compared, cycles, base} = '0;
        {move_len, move_reg, move_addr, core_result, loc_drive, snap} = '0;
        t_reset();
        t_instr();
        t_move();
        t_boot();
        finish_test();
    end
endmodule : tb_fpu_bus_interface_bootstrap
`default_nettype wire
